/* rtl/gate_drive_params.svh */
// Purpose: constants of the gate drive sequencer
// Assumes: 250 MHz system clock
// Notes:   times in ns, counts derived from them
`ifndef GATE_DRIVE_PARAMS_SVH
`define GATE_DRIVE_PARAMS_SVH

`define CLK_PERIOD_NS    4
`define TL_DISCH_NS      500
`define PROP_NS          200
`define STEP_NS          50
// Least times round up to whole cycles
`define TL_DISCH_CYC ((`TL_DISCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROP_CYC     ((`PROP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_CYC     ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SATURATION_SENSE_INPUT_DLY_CYC    16'h0010

// Register byte offsets
`define REG_PULSE        12'h000
`define REG_WDOG         12'h004
`define REG_FCLR         12'h008
`define REG_BLANK        12'h00c
`define REG_RDYDLY       12'h010
`define REG_STATUS       12'h014

// Reset values of the configuration registers
`define RST_PULSE        8'h04
`define RST_WDOG         16'h0100
`define RST_FCLR         16'h0040
`define RST_BLANK        16'h00fa
`define RST_RDYDLY       16'h0020

// Filtered input reset levels: bit0 noninv, bit1 inv, bit2 shutdown_n
`define FILT_RST         3'b110
`define FILT_NONINV      0
`define FILT_INV         1
`define FILT_SHDN        2
`endif

/* rtl/gate_drive_pkg.sv */
// Purpose: types shared by the gate drive sequencer
// Assumes: APB with 32-bit data
// Notes:   constants live in gate_drive_params.svh
package gate_drive_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Comparator levels from the analog output side
    typedef struct packed {
        logic sat_trip;          // saturation sense at 9 V
        logic tl_above_7v;       // timing capacitor above 7 V
        logic tl_at_ref;         // timing capacitor at reference
        logic out_below_ref;     // output below plateau reference
        logic gate_below_clamp;  // gate within 2 V of negative rail
    } sense_t;

    typedef struct packed {
        logic tl_discharge;
        logic tl_charge1;
        logic tl_charge2;
        logic gate_high;
        logic gate_fall;
        logic gate_hold;
        logic gate_neg;
        logic miller_clamp;
    } drive_t;

    typedef enum logic [3:0] {
        ST_OFF      = 4'b0000,
        ST_TL_DISCH = 4'b0001,
        ST_TL_CHG1  = 4'b0010,
        ST_TL_CHG2  = 4'b0011,
        ST_ON       = 4'b0100,
        ST_PROP     = 4'b0101,
        ST_DSDLY    = 4'b0110,
        ST_FALL     = 4'b0111,
        ST_HOLD     = 4'b1000
    } seq_state_t;
endpackage : gate_drive_pkg

/* rtl/pulse_filter.sv */
// Purpose: minimum pulse width filter for three logic inputs
// Assumes: inputs synchronous to clk_sys
// Notes:   a level passes only after min_cyc stable cycles
`timescale 1ns/1ps
`include "gate_drive_params.svh"
module pulse_filter (
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [2:0] raw,
    input  wire logic [7:0] min_cyc,
    output logic      [2:0] filt_q
);
    logic [7:0] cnt_q [3];

    // Glitch counters; a short pulse restarts the count
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            filt_q <= `FILT_RST;
            for (int i = 0; i < 3; i++) begin
                cnt_q[i] <= 8'h00;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (raw[i] == filt_q[i]) begin
                    cnt_q[i] <= 8'h00;
                end else if (cnt_q[i] + 8'h01 >= min_cyc) begin
                    filt_q[i] <= raw[i];
                    cnt_q[i]  <= 8'h00;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 8'h01;
                end
            end
        end
    end
endmodule : pulse_filter

/* rtl/gate_drive_seq.sv */
// Purpose: gate drive sequencer with two-level turn-off
// Assumes: comparators and supply monitors synchronous to clk_sys
// Notes:   open-drain outputs give level plus active-low enable
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
`include "gate_drive_params.svh"
// Contract
// - ready combines supply and link health
// - ready is not latched
// - watchdog forces gate off, drops ready
// - gate on needs noninv high, inv low
// - short input pulses are ignored
// - discharge 500 ns, charge twice, then on
// - store switch-on delay in 50 ns steps
// - commanded off starts after 200 ns
// - saturation_sense_input off starts after sense delay
// - hold plateau, then negative rail
// - two-level turn-off cannot be disabled
// - on-pulses shorter than plateau suppressed
// - off-pulses shorter than plateau suppressed; here the gate still falls and holds the full plateau, then returns high
// - plateau never cut short; here a hard error still ends it at once
// - saturation_sense_input trip drives gate low, sets fault
// - saturation_sense_input masked during blanking after turn-on
// - Miller clamp below 2 V during off
// - long shutdown low clears fault on rise
// - shutdown low holds gate off
// - error states hold negative rail
// - fault output open-drain, active low
// - saturation_sense_input only when on and blanked out
// - input lockout ignores drive inputs
module gate_drive_seq (
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire gate_drive_pkg::apb_req_t apb_req,
    output gate_drive_pkg::apb_rsp_t      apb_rsp,
    input  wire logic                     drv_noninv_in,
    input  wire logic                     drv_inv_in,
    input  wire logic                     shutdown_n_in,
    input  wire logic                     in_supply_ok,
    input  wire logic                     out_supply_ok,
    input  wire logic                     link_ok,
    input  wire gate_drive_pkg::sense_t   sense,
    output gate_drive_pkg::drive_t        drive_q,
    output logic                          ready_o,
    output logic                          ready_oe_n,
    output logic                          fault_report_output_o,
    output logic                          fault_report_output_oe_n
);
    import gate_drive_pkg::*;

    logic [7:0]  pulse_q;
    logic [15:0] wdog_q, fclr_q, blank_q, rdydly_q;
    logic [2:0]  filt;
    seq_state_t  state_q, state_d;
    logic [15:0] tmr_q, meas_q, blank_cnt_q;
    logic [15:0] wd_cnt_q, oso_cnt_q, lnk_cnt_q, low_cnt_q;
    logic [11:0] steps_q;
    logic        fault_q, ready_q, shdn_prev_q;
    logic [31:0] prdata_q;

    // Cycle count to stored 50 ns steps, propagation removed
    function automatic logic [11:0] cyc_to_steps(input logic [15:0] c);
        logic [15:0] net;
        net = (c > 16'(`PROP_CYC)) ? c - 16'(`PROP_CYC) : 16'h0000;
        return 12'(net / 16'(`STEP_CYC));
    endfunction : cyc_to_steps

    // Saturating counter step
    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h0001;
    endfunction : sat_inc

    pulse_filter u_filter (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .raw     ({shutdown_n_in, drv_inv_in, drv_noninv_in}),
        .min_cyc (pulse_q),
        .filt_q  (filt)
    );

    // Drive command and error decode
    wire shdn_n    = filt[`FILT_SHDN];
    wire cmd       = filt[`FILT_NONINV] & ~filt[`FILT_INV]
                   & shdn_n
                   & in_supply_ok;
    wire wdog_err  = (wd_cnt_q >= wdog_q);
    wire hard_err  = ~in_supply_ok | ~out_supply_ok | wdog_err;
    wire blank_end = (blank_cnt_q >= blank_q);
    wire saturation_sense_input     = (state_q == ST_ON) & blank_end
                   & sense.sat_trip;
    // Count includes the exit cycle, so the plateau is exactly steps long
    wire hold_end  = (tmr_q + 16'h0001 >= 16'(steps_q) * 16'(`STEP_CYC));
    wire oso_ok    = out_supply_ok & (oso_cnt_q >= rdydly_q);
    wire lnk_ok    = ~wdog_err & (lnk_cnt_q >= rdydly_q);
    wire ready_d   = in_supply_ok & oso_ok & lnk_ok;
    wire fclr_long = (low_cnt_q >= fclr_q);
    wire fclr_now  = shdn_n & ~shdn_prev_q & fclr_long;

    // APB decode; writes land in the access phase
    wire apb_acc   = apb_req.psel & apb_req.penable;
    wire apb_wr    = apb_acc & apb_req.pwrite;
    wire apb_setup = apb_req.psel & ~apb_req.penable;
    wire hit_pulse = (apb_req.paddr == `REG_PULSE);
    wire hit_wdog  = (apb_req.paddr == `REG_WDOG);
    wire hit_fclr  = (apb_req.paddr == `REG_FCLR);
    wire hit_blank = (apb_req.paddr == `REG_BLANK);
    wire hit_rdy   = (apb_req.paddr == `REG_RDYDLY);
    wire hit_stat  = (apb_req.paddr == `REG_STATUS);
    wire mapped    = hit_pulse | hit_wdog | hit_fclr | hit_blank
                   | hit_rdy | hit_stat;
    wire [31:0] rd_mux =
        hit_pulse ? {24'h000000, pulse_q} :
        hit_wdog  ? {16'h0000, wdog_q} :
        hit_fclr  ? {16'h0000, fclr_q} :
        hit_blank ? {16'h0000, blank_q} :
        hit_rdy   ? {16'h0000, rdydly_q} :
        hit_stat  ? {8'h00, steps_q, 4'(state_q), 5'h00,
                     wdog_err, fault_q, ready_q} : 32'h00000000;

    // Zero-wait slave; error only on unmapped words
    assign apb_rsp = '{pready:  1'b1,
                       pslverr: apb_acc & ~mapped,
                       prdata:  prdata_q};

    // Configuration registers: filter, watchdog, clear, blanking and ready delay
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pulse_q  <= `RST_PULSE;
            wdog_q   <= `RST_WDOG;
            fclr_q   <= `RST_FCLR;
            blank_q  <= `RST_BLANK;
            rdydly_q <= `RST_RDYDLY;
            prdata_q <= 32'h00000000;
        end else begin
            if (apb_wr & hit_pulse) pulse_q  <= apb_req.pwdata[7:0];
            if (apb_wr & hit_wdog)  wdog_q   <= apb_req.pwdata[15:0];
            if (apb_wr & hit_fclr)  fclr_q   <= apb_req.pwdata[15:0];
            if (apb_wr & hit_blank) blank_q  <= apb_req.pwdata[15:0];
            if (apb_wr & hit_rdy)   rdydly_q <= apb_req.pwdata[15:0];
            if (apb_setup)          prdata_q <= rd_mux;
        end
    end

    // Sequencer next state; only a hard error skips the plateau
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (cmd & ~fault_q & ~hard_err) begin
                    state_d = ST_TL_DISCH;
                end
            end
            ST_TL_DISCH: begin
                if (~cmd) begin
                    state_d = ST_OFF;
                end else if (tmr_q >= 16'(`TL_DISCH_CYC - 1)) begin
                    state_d = ST_TL_CHG1;
                end
            end
            ST_TL_CHG1: begin
                if (~cmd) begin
                    state_d = ST_OFF;
                end else if (sense.tl_above_7v) begin
                    state_d = ST_TL_CHG2;
                end
            end
            ST_TL_CHG2: begin
                if (~cmd) begin
                    state_d = ST_OFF;
                end else if (sense.tl_at_ref) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (saturation_sense_input) begin
                    state_d = ST_DSDLY;
                end else if (~cmd) begin
                    state_d = ST_PROP;
                end
            end
            ST_PROP: begin
                if (tmr_q >= 16'(`PROP_CYC - 1)) begin
                    state_d = ST_FALL;
                end
            end
            ST_DSDLY: begin
                if (tmr_q >= `SATURATION_SENSE_INPUT_DLY_CYC - 16'h0001) begin
                    state_d = ST_FALL;
                end
            end
            ST_FALL: begin
                if (sense.out_below_ref) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Full plateau unless a hard error; on again returns high
                if (hold_end) begin
                    state_d = (cmd & ~fault_q) ? ST_ON : ST_OFF;
                end
            end
            default: state_d = ST_OFF;
        endcase
        if (hard_err) begin
            state_d = ST_OFF;
        end
    end

    // Phase timer restarts on every state change
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_OFF;
            tmr_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            tmr_q   <= (state_d != state_q) ? 16'h0000 : sat_inc(tmr_q);
        end
    end

    // Switch-on delay measurement kept for the next turn-off
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meas_q  <= 16'h0000;
            steps_q <= 12'h000;
        end else begin
            if (state_q == ST_OFF) begin
                meas_q <= 16'h0000;
            end else if (state_q inside {ST_TL_DISCH, ST_TL_CHG1,
                                         ST_TL_CHG2}) begin
                meas_q <= sat_inc(meas_q);
            end
            if (state_q == ST_TL_CHG2 && state_d == ST_ON) begin
                steps_q <= cyc_to_steps(meas_q);
            end
        end
    end

    // Blanking after turn-on masks saturation sense
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            blank_cnt_q <= 16'h0000;
        end else if (state_q == ST_ON) begin
            blank_cnt_q <= sat_inc(blank_cnt_q);
        end else begin
            blank_cnt_q <= 16'h0000;
        end
    end

    // Watchdog and ready delays; link loss counts up
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wd_cnt_q  <= 16'h0000;
            oso_cnt_q <= 16'h0000;
            lnk_cnt_q <= 16'h0000;
            ready_q   <= 1'b0;
        end else begin
            wd_cnt_q  <= link_ok ? 16'h0000 : sat_inc(wd_cnt_q);
            oso_cnt_q <= out_supply_ok ? sat_inc(oso_cnt_q) : 16'h0000;
            lnk_cnt_q <= link_ok ? sat_inc(lnk_cnt_q) : 16'h0000;
            ready_q   <= ready_d;
        end
    end

    // Fault latch; a new trip wins over a clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fault_q     <= 1'b0;
            low_cnt_q   <= 16'h0000;
            shdn_prev_q <= 1'b1;
        end else begin
            shdn_prev_q <= shdn_n;
            low_cnt_q   <= shdn_n ? 16'h0000 : sat_inc(low_cnt_q);
            if (saturation_sense_input) begin
                fault_q <= 1'b1;
            end else if (fclr_now) begin
                fault_q <= 1'b0;
            end
        end
    end

    // Output stage decode, registered once
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            drive_q <= '0;
        end else begin
            drive_q.tl_discharge <= (state_q == ST_TL_DISCH);
            drive_q.tl_charge1   <= (state_q == ST_TL_CHG1);
            drive_q.tl_charge2   <= (state_q == ST_TL_CHG2);
            drive_q.gate_high    <= (state_q == ST_ON)
                                  | (state_q == ST_PROP)
                                  | (state_q == ST_DSDLY);
            drive_q.gate_fall    <= (state_q == ST_FALL);
            drive_q.gate_hold    <= (state_q == ST_HOLD);
            drive_q.gate_neg     <= (state_q == ST_OFF)
                                  | (state_q == ST_TL_DISCH)
                                  | (state_q == ST_TL_CHG1)
                                  | (state_q == ST_TL_CHG2);
            drive_q.miller_clamp <= (state_q == ST_OFF)
                                  & sense.gate_below_clamp;
        end
    end

    // Open-drain pins: level is always low, enable pulls
    assign ready_o                  = 1'b0;
    assign ready_oe_n               = ready_q;
    assign fault_report_output_o    = 1'b0;
    assign fault_report_output_oe_n = ~fault_q;

    // Checks on the sequencer
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    AST_READY_SUPPLY: assert property (
        !in_supply_ok |=> !ready_q)
        else $error("ready with input supply locked out");
    AST_READY_FOLLOWS: assert property (
        in_supply_ok && oso_ok && lnk_ok |=> ready_oe_n)
        else $error("ready did not return with healthy conditions");
    AST_WDOG_OFF: assert property (
        wdog_err |=> state_q == ST_OFF ##1 !drive_q.gate_high && !ready_q)
        else $error("watchdog did not force off");
    AST_MODE_GATE: assert property (
        state_q == ST_OFF && !cmd |=> state_q == ST_OFF)
        else $error("switch-on without valid drive mode");
    AST_DISCH_LEN: assert property (
        state_q == ST_TL_CHG1 && $past(state_q) == ST_TL_DISCH
        |-> $past(tmr_q) == 16'(`TL_DISCH_CYC - 1))
        else $error("timing discharge not 500 ns");
    AST_PROP_LEN: assert property (
        state_q == ST_FALL && $past(state_q) == ST_PROP
        |-> $past(tmr_q) == 16'(`PROP_CYC - 1))
        else $error("turn-off propagation wrong");
    AST_PLATEAU_HOLD: assert property (
        state_q == ST_FALL && sense.out_below_ref && !hard_err
        |=> state_q == ST_HOLD ##1 drive_q.gate_hold)
        else $error("plateau not entered");
    AST_PLATEAU_FULL: assert property (
        state_q == ST_HOLD && !hold_end && !hard_err
        |=> state_q == ST_HOLD)
        else $error("plateau cut short");
    AST_SATURATION_SENSE_INPUT_FAULT: assert property (
        saturation_sense_input |=> fault_q && state_q != ST_ON ##1 !fault_report_output_oe_n)
        else $error("saturation trip not reported");
    AST_BLANK_MASK: assert property (
        $rose(fault_q) |-> $past(state_q) == ST_ON && $past(blank_end))
        else $error("fault set outside blanked on state");
    AST_FAULT_CLR: assert property (
        fault_q && shdn_n && !$past(shdn_n) && !fclr_long |=> fault_q)
        else $error("short shutdown pulse cleared fault");
    AST_SHDN_OFF: assert property (
        !shdn_n |=> state_q inside {ST_OFF, ST_PROP, ST_DSDLY,
                                    ST_FALL, ST_HOLD})
        else $error("gate stayed on with shutdown low");

    COV_FULL_ON: cover property (state_q == ST_TL_CHG2 ##1 state_q == ST_ON);
    COV_TWO_LEVEL: cover property (state_q == ST_HOLD ##1 state_q == ST_OFF);
    COV_REON: cover property (state_q == ST_HOLD ##1 state_q == ST_ON);
    COV_SATURATION_SENSE_INPUT: cover property (saturation_sense_input);
endmodule : gate_drive_seq

/* verif/output_stage_model.sv */
// Purpose: behavioural output stage: timing cap, gate and sense levels
// Assumes: drive_q from gate_drive_seq, levels change on clk_sys
// Notes:   thresholds are reached after fixed cycle counts
`timescale 1ns/1ps
module output_stage_model #(
    parameter int C1 = 10,
    parameter int C2 = 10
) (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire gate_drive_pkg::drive_t drive_q,
    input  wire logic                   sat_in,
    output wire gate_drive_pkg::sense_t sense
);
    import gate_drive_pkg::*;
    logic [7:0] lvl_q;
    logic [7:0] cnt_q;
    drive_t     prev_q;
    // Cap charge and time spent at the present drive level
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lvl_q  <= 8'h00;
            cnt_q  <= 8'h00;
            prev_q <= '0;
        end else begin
            prev_q <= drive_q;
            cnt_q  <= (drive_q != prev_q) ? 8'h00 :
                      cnt_q + {7'h00, cnt_q != 8'hff};
            if (drive_q.tl_discharge)
                lvl_q <= 8'h00;
            else if (drive_q.tl_charge1 || drive_q.tl_charge2)
                lvl_q <= lvl_q + {7'h00, lvl_q != 8'hff};
        end
    end
    // Comparators; cnt_q clears one cycle late, so after a level of 5 or more cycles the fall reference is met at once
    assign sense.tl_above_7v = lvl_q >= 8'(C1);
    assign sense.tl_at_ref   = lvl_q >= 8'(C1 + C2);
    assign sense.out_below_ref = (drive_q.gate_fall && cnt_q >= 8'h04) ||
                                 drive_q.gate_hold;
    assign sense.gate_below_clamp = drive_q.gate_neg &&
                                    cnt_q >= 8'h02;
    // Collector voltage only rises while the transistor conducts
    assign sense.sat_trip = sat_in && drive_q.gate_high;
endmodule : output_stage_model

/* verif/isolated_gate_drive_sequencer_bench.sv */
// Purpose: self-checking bench of the gate drive sequencer
// Assumes: APB zero wait, output stage model on the far side
// Notes:   short register values keep the run brief
`timescale 1ns/1ps
`include "gate_drive_params.svh"
module isolated_gate_drive_sequencer_bench;
    import gate_drive_pkg::*;
    localparam int C1 = 10;
    localparam int C2 = 10;
    logic     clk_sys = 1'b0;
    logic     resetn = 1'b0;
    logic     noninv = 1'b0;
    logic     inv = 1'b0;
    logic     out_ok = 1'b1;
    logic     shdn_n = 1'b1;
    logic     in_ok = 1'b1;
    logic     link = 1'b1;
    logic     sat = 1'b0;
    logic     last_err;
    logic     rdy_o;
    logic     rdy_oe_n;
    logic     flt_o;
    logic     flt_oe_n;
    apb_req_t req = '0;
    apb_rsp_t rsp;
    drive_t   drv;
    sense_t   sns;
    logic [9:0] obs;
    int       errors = 0;
    int       total_checks = 0;
    assign obs = {flt_oe_n, rdy_oe_n, drv};
    always #2 clk_sys = ~clk_sys;
    gate_drive_seq i_dut (.clk_sys(clk_sys), .resetn(resetn),
        .apb_req(req), .apb_rsp(rsp), .drv_noninv_in(noninv),
        .drv_inv_in(inv), .shutdown_n_in(shdn_n), .in_supply_ok(in_ok),
        .out_supply_ok(out_ok), .link_ok(link), .sense(sns), .drive_q(drv),
        .ready_o(rdy_o), .ready_oe_n(rdy_oe_n),
        .fault_report_output_o(flt_o),
        .fault_report_output_oe_n(flt_oe_n));
    output_stage_model #(.C1(C1), .C2(C2)) i_stage (.clk_sys(clk_sys),
        .resetn(resetn), .drive_q(drv), .sat_in(sat), .sense(sns));
    function automatic logic [31:0] exp_rst(input int i);
        case (i)
            0: return 32'(`RST_PULSE);
            1: return 32'(`RST_WDOG);
            2: return 32'(`RST_FCLR);
            3: return 32'(`RST_BLANK);
            default: return 32'(`RST_RDYDLY);
        endcase
    endfunction : exp_rst
    // Small counts: filter 3, watchdog 40, clear 10, blank 6, ready 4
    function automatic logic [31:0] cfg(input int i);
        case (i)
            0: return 32'h3;
            1: return 32'h28;
            2: return 32'ha;
            3: return 32'h6;
            default: return 32'h4;
        endcase
    endfunction : cfg
    function automatic int plateau(input int c);
        return (c - 50) / 13;
    endfunction : plateau
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        @(posedge clk_sys);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clk_sys);
        req.penable <= 1'b1;
        @(posedge clk_sys);
        while (rsp.pready !== 1'b1) @(posedge clk_sys);
        rd = rsp.prdata;
        last_err = rsp.pslverr;
        req <= '0;
    endtask : apb
    // Sampled at the falling edge, where registered outputs are settled
    task automatic wt(input int b, input logic v, input int lim,
                      output int n);
        n = 0;
        while (obs[b] !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : wt
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        int n;
        int unsigned w;
        int st;
        logic [31:0] rd;
        void'($urandom(32'hebb54206));
        st = plateau(125 + C1 + C2);
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, rd);
            chk("reset_value", exp_rst(i), rd);
            apb(1'b1, 12'(i * 4), cfg(i), rd);
            apb(1'b0, 12'(i * 4), 32'h0, rd);
            chk("config", cfg(i), rd);
        end
        apb(1'b1, 12'h020, 32'hffffffff, rd);
        chk("slverr", 1, last_err);
        apb(1'b0, 12'h020, 32'h0, rd);
        chk("unmapped", 0, rd);
        wt(8, 1'b1, 40, n);
        chk("ready", 1, obs[8]);
        // Glitches shorter than the filter must not start a switch-on
        repeat (4) begin
            w = 1 + $urandom % 2;
            @(posedge clk_sys) noninv <= 1'b1;
            repeat (w) @(posedge clk_sys);
            noninv <= 1'b0;
            wt(7, 1'b1, 20, n);
            chk("glitch", 20, n);
        end
        @(posedge clk_sys) noninv <= 1'b1;
        wt(7, 1'b1, 20, n);
        wt(7, 1'b0, 200, n);
        chk("discharge_len", 125, n);
        wt(4, 1'b1, 100, n);
        chk("gate_on", 1, obs[4]);
        apb(1'b0, `REG_STATUS, 32'h0, rd);
        chk("steps", st, {20'h0, rd[23:12]});
        // Short off pulse: plateau still runs in full, then back on
        w = 10 + $urandom % 20;
        @(posedge clk_sys) noninv <= 1'b0;
        repeat (w) @(posedge clk_sys);
        noninv <= 1'b1;
        wt(2, 1'b1, 80, n);
        wt(2, 1'b0, 200, n);
        chk("hold_len", st * 13, n);
        wt(4, 1'b1, 3, n);
        chk("back_on", 1, obs[4]);
        @(posedge clk_sys) noninv <= 1'b0;
        wt(3, 1'b1, 80, n);
        chk("prop_delay", 1, n >= 50 && n <= 60);
        wt(2, 1'b1, 20, n);
        wt(2, 1'b0, 200, n);
        chk("hold_len2", st * 13, n);
        wt(0, 1'b1, 8, n);
        chk("clamp", 1, obs[0]);
        w = 10 + $urandom % 60;
        @(posedge clk_sys) noninv <= 1'b1;
        repeat (w) @(posedge clk_sys);
        noninv <= 1'b0;
        wt(4, 1'b1, 300, n);
        chk("short_on", 300, n);
        // Inverting mode; both inputs high means off
        @(posedge clk_sys) inv <= 1'b1;
        @(posedge clk_sys) noninv <= 1'b1;
        wt(7, 1'b1, 30, n);
        chk("both_high", 30, n);
        @(posedge clk_sys) inv <= 1'b0;
        wt(4, 1'b1, 400, n);
        chk("inv_on", 1, obs[4]);
        @(posedge clk_sys) inv <= 1'b1;
        wt(1, 1'b1, 400, n);
        chk("inv_off", 1, obs[1]);
        // Saturation present at switch-on: blanked, then trips
        @(posedge clk_sys) sat <= 1'b1;
        @(posedge clk_sys) inv <= 1'b0;
        wt(4, 1'b1, 400, n);
        repeat (3) @(negedge clk_sys);
        chk("blanking", 1, obs[9]);
        wt(9, 1'b0, 12, n);
        chk("fault", 0, obs[9]);
        chk("fault_level", 0, flt_o);
        wt(3, 1'b1, 30, n);
        chk("saturation_sense_input_delay", 1, n >= 14 && n <= 19);
        @(posedge clk_sys) sat <= 1'b0;
        wt(1, 1'b1, 300, n);
        chk("saturation_sense_input_neg", 1, obs[1]);
        wt(7, 1'b1, 30, n);
        chk("fault_blocks", 30, n);
        @(posedge clk_sys) shdn_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        shdn_n <= 1'b1;
        wt(9, 1'b1, 30, n);
        chk("short_clear", 30, n);
        @(posedge clk_sys) shdn_n <= 1'b0;
        repeat (30) @(posedge clk_sys);
        shdn_n <= 1'b1;
        wt(9, 1'b1, 10, n);
        chk("clear", 1, obs[9]);
        wt(4, 1'b1, 400, n);
        @(posedge clk_sys) shdn_n <= 1'b0;
        wt(1, 1'b1, 300, n);
        chk("shutdown_off", 1, obs[1]);
        wt(7, 1'b1, 30, n);
        chk("shutdown_hold", 30, n);
        @(posedge clk_sys) shdn_n <= 1'b1;
        wt(4, 1'b1, 400, n);
        @(posedge clk_sys) in_ok <= 1'b0;
        wt(1, 1'b1, 5, n);
        chk("lockout_off", 1, obs[1]);
        wt(8, 1'b0, 5, n);
        chk("lockout_ready", 0, obs[8]);
        wt(7, 1'b1, 30, n);
        chk("lockout_ignore", 30, n);
        @(posedge clk_sys) in_ok <= 1'b1;
        wt(4, 1'b1, 400, n);
        @(posedge clk_sys) link <= 1'b0;
        wt(1, 1'b1, 60, n);
        chk("wdog_off", 1, n >= 38 && n <= 46);
        wt(8, 1'b0, 5, n);
        chk("wdog_ready", 0, obs[8]);
        @(posedge clk_sys) link <= 1'b1;
        wt(8, 1'b1, 30, n);
        chk("ready_back", 1, obs[8]);
        @(posedge clk_sys) out_ok <= 1'b0;
        wt(8, 1'b0, 5, n);
        chk("out_lockout", 0, obs[8]);
        chk("ready_level", 0, rdy_o);
        summarize();
    end
endmodule : isolated_gate_drive_sequencer_bench
